// ===== logic/trc_reset_defines.vh
// Constants for the transceiver reset controller.
`ifndef TRC_RESET_DEFINES_VH
`define TRC_RESET_DEFINES_VH

// Clock rate in kHz (20 MHz).
`define TRC_CLK_KHZ 20000
// Power-on reset length in microseconds (100 ms).
`define TRC_POR_TIME_US 100000
// Software reset length in microseconds (0.25 ms, typical).
`define TRC_SWR_TIME_US 250
// Derived cycle counts; both times divide exactly into whole cycles.
`define TRC_POR_CYCLES ((`TRC_POR_TIME_US * `TRC_CLK_KHZ) / 1000)
`define TRC_SWR_CYCLES ((`TRC_SWR_TIME_US * `TRC_CLK_KHZ) / 1000)
// Software reset command word.
`define TRC_CMD_SW_RESET 16'hFE00
// FIFO and reset mode command: upper byte and the mode bit position.
`define TRC_CMD_FIFO_MODE_HI 8'hCA
`define TRC_MODE_BIT 0
// Command opcode field: the upper byte of the word.
`define TRC_OP_MSB 15
`define TRC_OP_LSB 8
// Register defaults.
`define TRC_MODE_SENSITIVE 1'b1
`define TRC_CMD_CLEAR 16'h0000
// Cause codes reported on the cause output.
`define TRC_CAUSE_NONE 2'h0
`define TRC_CAUSE_POR 2'h1
`define TRC_CAUSE_GLITCH 2'h2
`define TRC_CAUSE_SW 2'h3
// Counter width.
`define TRC_CNT_W 22

`endif

// ===== logic/trc_reset_timer.v
// Down counter that times one reset interval.
`timescale 1ns/100ps
`default_nettype none
`include "trc_reset_defines.vh"

module trc_reset_timer #(
    parameter CNT_W = `TRC_CNT_W
)
(
    input wire clock,
    input wire rst_n,
    input wire load,
    input wire [CNT_W-1:0] load_value,
    output reg busy
);
    reg [CNT_W-1:0] count;

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            count <= {CNT_W{1'b0}};
            busy <= 1'b0;
        end
        else if (load)
        begin
            count <= load_value;
            busy <= 1'b1;
        end
        else if (count > {{(CNT_W-1){1'b0}}, 1'b1})
        begin
            count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
        end
        else
        begin
            count <= {CNT_W{1'b0}};
            busy <= 1'b0;
        end
    end
endmodule // trc_reset_timer

`default_nettype wire

// ===== logic/trc_reset_control.v
// Reset control for a radio transceiver: causes, modes and command gating.
// Notes on behaviour
// RULE1: Reset is entered on power-on, a positive supply glitch, or the reset command.
// RULE2: No serial command is accepted during power-on reset, up to 100 ms.
// RULE3: Reset mode defaults to sensitive; mode command bit 0 high selects normal.
// RULE4: Normal mode disables supply glitch detection entirely.
// RULE5: Sensitive mode resets on detector rise above 100 mV/ms with 600 mV gap.
// RULE6: Command word FE00h triggers a software reset.
// RULE7: Software reset acts like power-on reset but lasts 0.25 ms.
// RULE8: Software reset command is honoured only in sensitive mode.
// RULE9: Every reset restores configuration defaults, so sensitive mode returns.
// RULE10: Commands arriving during software or glitch reset are discarded too.
`timescale 1ns/100ps
`default_nettype none
`include "trc_reset_defines.vh"

module trc_reset_control #(
    parameter POR_CYCLES = `TRC_POR_CYCLES,
    parameter SWR_CYCLES = `TRC_SWR_CYCLES,
    parameter CNT_W = `TRC_CNT_W
)
(
    input wire clock,
    input wire rst_n,
    input wire power_on_event,
    input wire glitch_detect,
    input wire cmd_valid,
    input wire [15:0] cmd_word,
    output reg chip_reset,
    output reg sensitive_mode,
    output reg cmd_accept,
    output reg [15:0] cmd_out,
    output reg [1:0] reset_cause
);
    // ****************************************************************
    // Constants and decode functions
    // ****************************************************************
    localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    // The timer keeps busy for as many cycles as it was loaded with, and
    // chip_reset trails busy by one register, so one cycle is taken off
    // here to make chip_reset last exactly the requested interval.
    localparam [CNT_W-1:0] POR_LOAD = POR_CYCLES[CNT_W-1:0] - ONE;
    localparam [CNT_W-1:0] SWR_LOAD = SWR_CYCLES[CNT_W-1:0] - ONE;

    // True for the dedicated software reset command word.
    function is_sw_reset_word;
        input [15:0] word;
        begin
            is_sw_reset_word = (word == `TRC_CMD_SW_RESET);
        end
    endfunction

    // True for the FIFO and reset mode command, whatever its low byte.
    function is_mode_word;
        input [15:0] word;
        begin
            is_mode_word = (word[`TRC_OP_MSB:`TRC_OP_LSB]
                == `TRC_CMD_FIFO_MODE_HI);
        end
    endfunction

    // Mode carried by a mode command: bit set is normal, clear sensitive.
    function mode_of_word;
        input [15:0] word;
        begin
            mode_of_word = !word[`TRC_MODE_BIT];
        end
    endfunction

    // ****************************************************************
    // Reset causes and interval timing
    // ****************************************************************
    wire busy;
    wire cmd_free;
    wire glitch_hit;
    wire sw_hit;
    reg next_load;
    reg [CNT_W-1:0] next_value;
    reg [1:0] next_cause;

    // The serial path is open only when no reset of any kind is running.
    assign cmd_free = !busy && !chip_reset; // RULE2 RULE10
    // The analogue detector already checks slope and threshold, so a
    // single level is all the digital side needs to see.
    assign glitch_hit = glitch_detect && sensitive_mode; // RULE4 RULE5
    // A reset word arriving during reset is dropped like any other command.
    assign sw_hit = cmd_valid && cmd_free && is_sw_reset_word(cmd_word)
        && sensitive_mode; // RULE6 RULE8

    always @*
    begin
        next_load = 1'b0;
        next_value = SWR_LOAD;
        next_cause = `TRC_CAUSE_NONE;
        // Power-on has priority so the longer interval is never cut short.
        if (power_on_event) // RULE1
        begin
            next_load = 1'b1;
            next_value = POR_LOAD;
            next_cause = `TRC_CAUSE_POR;
        end
        else if (glitch_hit) // RULE1
        begin
            next_load = 1'b1;
            next_value = POR_LOAD;
            next_cause = `TRC_CAUSE_GLITCH;
        end
        else if (sw_hit) // RULE1 RULE7
        begin
            next_load = 1'b1;
            next_value = SWR_LOAD;
            next_cause = `TRC_CAUSE_SW;
        end
    end

    // A power-on or glitch cause that stays present reloads the timer every cycle, so reset
    // is held for the full interval after the last cycle of the cause.
    trc_reset_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .load(next_load),
        .load_value(next_value),
        .busy(busy)
    );

    // ****************************************************************
    // Next values of the outputs
    // ****************************************************************
    reg next_chip_reset;
    reg next_sensitive;
    reg next_accept;
    reg [15:0] next_cmd_out;
    reg [1:0] next_reset_cause;

    // Any reset restores the default mode, so a host that chose normal mode
    // must send the mode command again once reset is over.
    always @*
    begin
        next_chip_reset = busy || next_load; // RULE1
        next_accept = 1'b0;
        next_cmd_out = cmd_out;
        next_sensitive = sensitive_mode;
        next_reset_cause = reset_cause;
        if (next_load)
        begin
            next_reset_cause = next_cause;
        end
        if (next_load || busy)
        begin
            next_sensitive = `TRC_MODE_SENSITIVE; // RULE9
        end
        else if (cmd_valid && cmd_free) // RULE2 RULE10
        begin
            next_accept = 1'b1;
            next_cmd_out = cmd_word;
            if (is_mode_word(cmd_word))
            begin
                next_sensitive = mode_of_word(cmd_word); // RULE3
            end
        end
    end

    // ****************************************************************
    // Output registers
    // ****************************************************************
    // Every output leaves from a flip-flop, so the host never sees a
    // combinational path from its own command back to its inputs.
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            chip_reset <= 1'b1;
        end
        else
        begin
            chip_reset <= next_chip_reset;
        end
    end

    // The cause is kept after reset ends so it still tells why the chip
    // last restarted.
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            reset_cause <= `TRC_CAUSE_POR;
        end
        else
        begin
            reset_cause <= next_reset_cause;
        end
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            sensitive_mode <= `TRC_MODE_SENSITIVE; // RULE3
        end
        else
        begin
            sensitive_mode <= next_sensitive;
        end
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            cmd_accept <= 1'b0;
            cmd_out <= `TRC_CMD_CLEAR;
        end
        else
        begin
            cmd_accept <= next_accept;
            cmd_out <= next_cmd_out;
        end
    end
endmodule // trc_reset_control

`default_nettype wire

// ===== verification/trc_reset_properties.sv
// Checker for the reset controller ports.
`timescale 1ns/100ps
`default_nettype none
module trc_reset_properties (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic power_on_event,
    input wire logic glitch_detect,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic chip_reset,
    input wire logic sensitive_mode,
    input wire logic cmd_accept,
    input wire logic [15:0] cmd_out,
    input wire logic [1:0] reset_cause
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic quiet = !chip_reset && !power_on_event;
    wire logic idle = quiet && !glitch_detect;
    wire logic sw = cmd_valid && cmd_word == 16'hFE00;
    wire logic swgo = idle && sw && sensitive_mode;
    wire logic go = idle && cmd_valid && !(sw && sensitive_mode);
    wire logic nglt = quiet && glitch_detect && !sensitive_mode;
    property p_sw; swgo |=> chip_reset && reset_cause == 2'h3; endproperty
    a_sw: assert property (p_sw) else $error("sw");
    property p_gl; glitch_detect && sensitive_mode |=> chip_reset; endproperty
    a_gl: assert property (p_gl) else $error("gl");
    property p_nm; nglt |=> !chip_reset; endproperty
    a_nm: assert property (p_nm) else $error("nm");
    property p_gt; chip_reset |=> !cmd_accept; endproperty
    a_gt: assert property (p_gt) else $error("gt");
    property p_ac;
        go |=> cmd_accept && cmd_out == $past(cmd_word);
    endproperty
    a_ac: assert property (p_ac) else $error("ac");
    property p_md;
        cmd_accept && cmd_out == 16'hCA01 |-> !sensitive_mode;
    endproperty
    a_md: assert property (p_md) else $error("md");
    property p_in; $rose(chip_reset) |=> sensitive_mode; endproperty
    a_in: assert property (p_in) else $error("in");
    property p_sl;
        $rose(chip_reset) && reset_cause == 2'h3 |->
            chip_reset[*8] ##[1:4] !chip_reset;
    endproperty
    a_sl: assert property (p_sl) else $error("sl");
endmodule // trc_reset_properties
`default_nettype wire

// ===== verification/trc_host_model.sv
// Host model: sends one command word per call.
`timescale 1ns/100ps
`default_nettype none
module trc_host_model (
    input wire logic clock,
    output logic cmd_valid,
    output logic [15:0] cmd_word
);
    initial {cmd_valid, cmd_word} = 17'h0AAAA;
    // A released word shows its inverse, so no stale value looks valid.
    task automatic send(input logic [15:0] w);
        @(posedge clock);
        {cmd_valid, cmd_word} <= {1'b1, w};
        @(posedge clock);
        {cmd_valid, cmd_word} <= {1'b0, ~w};
    endtask
endmodule // trc_host_model
`default_nettype wire

// ===== verification/tb_top.sv
// Testbench for the transceiver reset controller.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic power_on_event = 1'b0;
    logic glitch_detect = 1'b0;
    wire logic cmd_valid, chip_reset, sensitive_mode, cmd_accept;
    wire logic [15:0] cmd_word, cmd_out;
    wire logic [1:0] reset_cause;
    int error_cnt = 0;
    int n_checks = 0;
    int c;
    logic [15:0] w;
    logic m;
    int i;
    always #25 clock = ~clock;
    // Short intervals keep the run brief; the logic is the same at any length.
    localparam int POR_LEN = 50;
    localparam int SWR_LEN = 10;
    trc_host_model u_trc_host_model (
        .clock(clock),
        .cmd_valid(cmd_valid),
        .cmd_word(cmd_word)
    );
    trc_reset_control #(
        .POR_CYCLES(POR_LEN),
        .SWR_CYCLES(SWR_LEN)
    ) u_trc_reset_control (
        .clock(clock),
        .rst_n(rst_n),
        .power_on_event(power_on_event),
        .glitch_detect(glitch_detect),
        .cmd_valid(cmd_valid),
        .cmd_word(cmd_word),
        .chip_reset(chip_reset),
        .sensitive_mode(sensitive_mode),
        .cmd_accept(cmd_accept),
        .cmd_out(cmd_out),
        .reset_cause(reset_cause)
    );
    // Mode after a command: the mode command's bit 0 set selects normal.
    function automatic logic mode_after(input logic [15:0] x, input logic s);
        return (x[15:8] == 8'hCA) ? ~x[0] : s;
    endfunction
    task automatic chk(input string n, input logic [15:0] s, e);
        n_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic hit(input logic p, g);
        @(posedge clock);
        {power_on_event, glitch_detect} <= {p, g};
        @(posedge clock);
        {power_on_event, glitch_detect} <= 2'b00;
        #1;
    endtask
    task automatic put(input logic [15:0] x);
        u_trc_host_model.send(x);
        #1;
    endtask
    // Counts the cycles chip_reset still stands, looking 1 ns after edges.
    task automatic settle;
        c = 0;
        while (c < 99 && chip_reset)
        begin
            @(posedge clock);
            #1;
            c++;
        end
        if (chip_reset)
        begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'h52A4));
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        put(16'hFE00);
        chk("cause", 16'(reset_cause), 16'h0003);
        settle();
        chk("swlen", 16'(c), 16'(SWR_LEN));
        hit(1'b0, 1'b1);
        chk("cause", 16'(reset_cause), 16'h0002);
        put(16'($urandom) & 16'h7FFF);
        chk("drop", 16'(cmd_accept), 16'h0000);
        settle();
        put(16'hCA01);
        chk("mode", 16'(sensitive_mode), 16'h0000);
        hit(1'b0, 1'b1);
        put(16'hFE00);
        chk("nrst", 16'(chip_reset), 16'h0000);
        chk("nacc", 16'(cmd_accept), 16'h0001);
        chk("nout", cmd_out, 16'hFE00);
        hit(1'b1, 1'b0);
        put(16'($urandom) & 16'h7FFF);
        chk("por", 16'({cmd_accept, reset_cause}), 16'h0001);
        settle();
        chk("mode", 16'(sensitive_mode), 16'h0001);
        m = 1'b1;
        for (i = 0; i < 24; i++)
        begin
            w = 16'($urandom);
            if (i % 2 == 1)
                w[15:8] = 8'hCA;
            if (w == 16'hFE00)
                w = 16'hFE01;
            put(w);
            m = mode_after(w, m);
            chk("racc", 16'(cmd_accept), 16'h0001);
            chk("rout", cmd_out, w);
            chk("rmode", 16'(sensitive_mode), 16'(m));
        end
        tally_and_finish();
    end
    initial
    begin
        // Far beyond the fewer than two hundred cycles the sequence needs.
        #200000;
        error_cnt++;
        tally_and_finish();
    end
endmodule // tb_top
bind trc_reset_control trc_reset_properties u_trc_reset_properties (
    .clock(clock),
    .rst_n(rst_n),
    .power_on_event(power_on_event),
    .glitch_detect(glitch_detect),
    .cmd_valid(cmd_valid),
    .cmd_word(cmd_word),
    .chip_reset(chip_reset),
    .sensitive_mode(sensitive_mode),
    .cmd_accept(cmd_accept),
    .cmd_out(cmd_out),
    .reset_cause(reset_cause)
);
`default_nettype wire
